// File: core/pcr_pkg.sv
// Constants and types shared by the PLL configuration register bank
// Overview of operation
// - Register 0 bit 0 always reads one; host should write one there.
// - Register 0 bits 9:7 pick loop filter capacitor, 35 pF up to 562.5 pF.
// - Register 0 bits 6:4 pick loop filter resistor, 10 up to 4010 ohms.
// - Register 0 bits 3:1 set pump current, 500 uA plus 0.5 mA per code.
// - Register 1 bits 15:2 hold reference divider; divide by value plus one.
// - Wide feedback divider spans register 1 bits 1:0 and register 2 bits 15:8.
// - Register 2 bits 7:0 hold narrow feedback divider; divide by value plus one.
// - Register 3 bits 12:10 route refclk, refloss, lock onto status pin B.
// - Register 3 bits 9:7 route refclk, refloss, lock onto status pin A.
// - Register 3 bit 6 low holds the device in reset, registers kept.
// - Register 3 bit 5 low holds output dividers in synchronization.
// - Register 3 bit 4 enables oscillator calibration.
// - Register 3 bits 3:2 pick second prescaler 4, 5 or 6; code 11 reserved.
// - Register 3 bits 1:0 pick first prescaler 4, 5 or 6; code 11 reserved.
// - Each sixteen-bit register moves as two bytes, high byte first.
package pcr_pkg;

    localparam int unsigned ADDR_W = 5;
    localparam int unsigned REG_W  = 16;
    localparam int unsigned BYTE_W = 8;

    // Register word offsets
    localparam logic [4:0] OFF_FILTER_PUMP = 5'h00;
    localparam logic [4:0] OFF_REFDIV_FBHI = 5'h01;
    localparam logic [4:0] OFF_FBDIV_LO    = 5'h02;
    localparam logic [4:0] OFF_STATUS_CTRL = 5'h03;

    // Field positions
    localparam int unsigned CAP_LSB     = 7;
    localparam int unsigned RES_LSB     = 4;
    localparam int unsigned PUMP_LSB    = 1;
    localparam int unsigned TIE_BIT     = 0;
    localparam int unsigned REFDIV_LSB  = 2;
    localparam int unsigned FBW_HI_LSB  = 0;
    localparam int unsigned FBW_LO_LSB  = 8;
    localparam int unsigned FBN_LSB     = 0;
    localparam int unsigned STB_REF_BIT = 12;
    localparam int unsigned STB_LOS_BIT = 11;
    localparam int unsigned STB_LCK_BIT = 10;
    localparam int unsigned STA_REF_BIT = 9;
    localparam int unsigned STA_LOS_BIT = 8;
    localparam int unsigned STA_LCK_BIT = 7;
    localparam int unsigned SRST_BIT    = 6;
    localparam int unsigned SYNC_BIT    = 5;
    localparam int unsigned CAL_BIT     = 4;
    localparam int unsigned PSB_LSB     = 2;
    localparam int unsigned PSA_LSB     = 0;

    // Writable masks and tied constants
    localparam logic [15:0] R0_WMASK = 16'h03FE;
    localparam logic [15:0] R0_TIE   = 16'h0001;
    localparam logic [15:0] R3_WMASK = 16'h1FFF;

    // Values after reset
    localparam logic [15:0] R0_RST = 16'h0001;
    localparam logic [15:0] R1_RST = 16'h0000;
    localparam logic [15:0] R2_RST = 16'h0000;
    localparam logic [15:0] R3_RST = 16'h0000;

    // Prescaler codes and ratios
    localparam logic [1:0] PS_DIV4 = 2'h0;
    localparam logic [1:0] PS_DIV5 = 2'h1;
    localparam logic [1:0] PS_DIV6 = 2'h2;
    localparam logic [2:0] RATIO4  = 3'h4;
    localparam logic [2:0] RATIO5  = 3'h5;
    localparam logic [2:0] RATIO6  = 3'h6;

    // Pump current step in microamps
    localparam logic [11:0] PUMP_STEP_UA = 12'h01F4;

    // Byte pairing states
    typedef enum logic [1:0] {
        PAIR_IDLE = 2'b01,
        PAIR_HIGH = 2'b10
    } pcr_pair_t;

endpackage

// File: core/pcr_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pcr_sync3 #(
    parameter int unsigned WIDTH = 3
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] raw_in,
    output logic      [WIDTH-1:0] clean_reg
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    // Stage one feeds only stage two, so metastability stays contained
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            s1_reg    <= '0;
            s2_reg    <= '0;
            s3_reg    <= '0;
            clean_reg <= '0;
        end
        else if (ce)
        begin
            s1_reg <= raw_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < WIDTH; i++)
            begin
                if (s2_reg[i] == s3_reg[i])
                    clean_reg[i] <= s2_reg[i];
            end
        end
    end
endmodule
`default_nettype wire

// File: core/pcr_byte_pair.sv
// Joins high and low host bytes into one sixteen-bit register write
`timescale 1ns/1ps
`default_nettype none
module pcr_byte_pair
    import pcr_pkg::*;
(
    input  wire logic                      core_clk,
    input  wire logic                      rst_b,
    input  wire logic                      ce,
    input  wire logic                      byte_stb,
    input  wire logic                      byte_msb,
    input  wire logic [pcr_pkg::ADDR_W-1:0] byte_addr,
    input  wire logic [7:0]                byte_data,
    output logic                           word_stb,
    output logic      [pcr_pkg::ADDR_W-1:0] word_addr,
    output logic      [15:0]               word_data
);
    pcr_pair_t       state_reg;
    logic [7:0]      high_reg;
    logic [ADDR_W-1:0] haddr_reg;

    // High byte waits; low byte to the same address completes the word
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            state_reg <= PAIR_IDLE;
            high_reg  <= 8'h00;
            haddr_reg <= '0;
            word_stb  <= 1'b0;
            word_addr <= '0;
            word_data <= 16'h0000;
        end
        else if (ce)
        begin
            word_stb <= 1'b0;
            case (state_reg)
                PAIR_IDLE:
                begin
                    if (byte_stb && byte_msb)
                    begin
                        high_reg  <= byte_data;
                        haddr_reg <= byte_addr;
                        state_reg <= PAIR_HIGH;
                    end
                end
                PAIR_HIGH:
                begin
                    if (byte_stb && byte_msb)
                    begin
                        // A repeated high byte replaces the held one
                        high_reg  <= byte_data;
                        haddr_reg <= byte_addr;
                    end
                    else if (byte_stb)
                    begin
                        // Mismatched address drops the pair quietly
                        word_stb  <= (byte_addr == haddr_reg);
                        word_addr <= haddr_reg;
                        word_data <= {high_reg, byte_data};
                        state_reg <= PAIR_IDLE;
                    end
                end
                default:
                    state_reg <= PAIR_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_pair_in;
        ce && byte_stb && byte_msb && state_reg == PAIR_IDLE
        ##1 ce && byte_stb && !byte_msb && byte_addr == haddr_reg;
    endsequence

    a_pair_commit: assert property (s_pair_in |=> word_stb)
        else $error("paired bytes produced no word write");
endmodule
`default_nettype wire

// File: core/pcr_bank.sv
// PLL configuration register bank: registers 0 to 3 and derived controls
`timescale 1ns/1ps
`default_nettype none
module pcr_bank
    import pcr_pkg::*;
(
    input  wire logic                       core_clk,
    input  wire logic                       rst_b,
    input  wire logic                       ce,
    input  wire logic                       host_wr_stb,
    input  wire logic                       host_rd_stb,
    input  wire logic                       host_msb,
    input  wire logic [pcr_pkg::ADDR_W-1:0] host_addr,
    input  wire logic [7:0]                 host_wr_byte,
    output logic      [7:0]                 host_rd_byte,
    output logic                            host_rd_valid,
    input  wire logic                       ref_clk_ok,
    input  wire logic                       ref_lost,
    input  wire logic                       pll_locked,
    output logic                            status_a,
    output logic                            status_b,
    output logic      [2:0]                 filter_cap_sel,
    output logic      [12:0]                filter_cap_tenth_pf,
    output logic      [2:0]                 filter_res_sel,
    output logic      [11:0]                filter_res_ohm,
    output logic      [2:0]                 pump_current_sel,
    output logic      [11:0]                pump_current_ua,
    output logic      [14:0]                ref_div_ratio,
    output logic      [10:0]                fb_wide_ratio,
    output logic      [8:0]                 fb_narrow_ratio,
    output logic                            core_hold,
    output logic                            divider_sync_hold,
    output logic                            vco_calibration_en,
    output logic      [2:0]                 prescaler_first_ratio,
    output logic      [2:0]                 prescaler_second_ratio,
    output logic                            prescaler_code_err
);
    logic [15:0]       cfg0_reg;
    logic [15:0]       cfg1_reg;
    logic [15:0]       cfg2_reg;
    logic [15:0]       cfg3_reg;
    logic              word_stb;
    logic [ADDR_W-1:0] word_addr;
    logic [15:0]       word_data;
    logic [2:0]        src_reg;
    logic [15:0]       rd_word;
    logic [2:0]        en_a;
    logic [2:0]        en_b;
    logic [1:0]        psa_code;
    logic [1:0]        psb_code;
    logic [9:0]        fbw_value;

    // Prescaler code to divide ratio; reserved code gives zero
    function automatic logic [2:0] presc_ratio(input logic [1:0] code);
        case (code)
            PS_DIV4: presc_ratio = RATIO4;
            PS_DIV5: presc_ratio = RATIO5;
            PS_DIV6: presc_ratio = RATIO6;
            default: presc_ratio = 3'h0;
        endcase
    endfunction

    // Capacitor code to tenths of pF; the undefined code reports zero
    function automatic logic [12:0] cap_tenths(input logic [2:0] code);
        case (code)
            3'h0:    cap_tenths = 13'h015E;
            3'h1:    cap_tenths = 13'h0465;
            3'h2:    cap_tenths = 13'h06EF;
            3'h3:    cap_tenths = 13'h0979;
            3'h4:    cap_tenths = 13'h0C1C;
            3'h5:    cap_tenths = 13'h0EBF;
            3'h7:    cap_tenths = 13'h15F9;
            default: cap_tenths = 13'h0000;
        endcase
    endfunction

    // Resistor code to ohms
    function automatic logic [11:0] res_ohm(input logic [2:0] code);
        case (code)
            3'h0:    res_ohm = 12'h00A;
            3'h1:    res_ohm = 12'h01E;
            3'h2:    res_ohm = 12'h03C;
            3'h3:    res_ohm = 12'h064;
            3'h4:    res_ohm = 12'h212;
            3'h5:    res_ohm = 12'h41A;
            3'h6:    res_ohm = 12'h820;
            default: res_ohm = 12'hFAA;
        endcase
    endfunction

    // Register image as seen by a read; unmapped words read zero
    function automatic logic [15:0] word_at(input logic [ADDR_W-1:0] a,
                                            input logic [15:0] r0,
                                            input logic [15:0] r1,
                                            input logic [15:0] r2,
                                            input logic [15:0] r3);
        case (a)
            OFF_FILTER_PUMP: word_at = r0;
            OFF_REFDIV_FBHI: word_at = r1;
            OFF_FBDIV_LO:    word_at = r2;
            OFF_STATUS_CTRL: word_at = r3;
            default:         word_at = 16'h0000;
        endcase
    endfunction

    // Host bytes become whole register writes
    pcr_byte_pair u_pair (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .ce        (ce),
        .byte_stb  (host_wr_stb),
        .byte_msb  (host_msb),
        .byte_addr (host_addr),
        .byte_data (host_wr_byte),
        .word_stb  (word_stb),
        .word_addr (word_addr),
        .word_data (word_data)
    );

    // Status sources come from the analog side, asynchronous to core_clk
    pcr_sync3 #(
        .WIDTH (3)
    ) u_sync (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .ce        (ce),
        .raw_in    ({ref_clk_ok, ref_lost, pll_locked}),
        .clean_reg (src_reg)
    );

    // Register storage; reserved bits are masked, bit 0 stays tied high
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            cfg0_reg <= R0_RST;
            cfg1_reg <= R1_RST;
            cfg2_reg <= R2_RST;
            cfg3_reg <= R3_RST;
        end
        else if (ce && word_stb)
        begin
            case (word_addr)
                OFF_FILTER_PUMP:
                    cfg0_reg <= (word_data & R0_WMASK) | R0_TIE;
                OFF_REFDIV_FBHI:
                    cfg1_reg <= word_data;
                OFF_FBDIV_LO:
                    cfg2_reg <= word_data;
                OFF_STATUS_CTRL:
                    cfg3_reg <= word_data & R3_WMASK;
                default:
                    cfg0_reg <= cfg0_reg;
            endcase
        end
    end

    // Read answer one cycle after the request, high or low byte
    assign rd_word = word_at(host_addr, cfg0_reg, cfg1_reg, cfg2_reg,
                             cfg3_reg);
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            host_rd_byte  <= 8'h00;
            host_rd_valid <= 1'b0;
        end
        else if (ce)
        begin
            host_rd_valid <= host_rd_stb;
            if (host_rd_stb)
                host_rd_byte <= host_msb ? rd_word[15:8] : rd_word[7:0];
        end
    end

    // Status pins: OR of the enabled sources
    assign en_b = {cfg3_reg[STB_REF_BIT], cfg3_reg[STB_LOS_BIT],
                   cfg3_reg[STB_LCK_BIT]};
    assign en_a = {cfg3_reg[STA_REF_BIT], cfg3_reg[STA_LOS_BIT],
                   cfg3_reg[STA_LCK_BIT]};
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            status_a <= 1'b0;
            status_b <= 1'b0;
        end
        else if (ce)
        begin
            status_a <= |(src_reg & en_a);
            status_b <= |(src_reg & en_b);
        end
    end

    // Loop filter and charge pump settings
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            filter_cap_sel      <= 3'h0;
            filter_cap_tenth_pf <= 13'h0000;
            filter_res_sel      <= 3'h0;
            filter_res_ohm      <= 12'h000;
            pump_current_sel    <= 3'h0;
            pump_current_ua     <= 12'h000;
        end
        else if (ce)
        begin
            filter_cap_sel      <= cfg0_reg[CAP_LSB +: 3];
            filter_cap_tenth_pf <= cap_tenths(cfg0_reg[CAP_LSB +: 3]);
            filter_res_sel      <= cfg0_reg[RES_LSB +: 3];
            filter_res_ohm      <= res_ohm(cfg0_reg[RES_LSB +: 3]);
            pump_current_sel    <= cfg0_reg[PUMP_LSB +: 3];
            pump_current_ua     <= 12'(PUMP_STEP_UA *
                                   ({9'h000, cfg0_reg[PUMP_LSB +: 3]}
                                    + 12'h001));
        end
    end

    // Divider ratios are stored value plus one
    assign fbw_value = {cfg1_reg[FBW_HI_LSB +: 2], cfg2_reg[FBW_LO_LSB +: 8]};
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            ref_div_ratio   <= 15'h0001;
            fb_wide_ratio   <= 11'h001;
            fb_narrow_ratio <= 9'h001;
        end
        else if (ce)
        begin
            ref_div_ratio   <= {1'b0, cfg1_reg[REFDIV_LSB +: 14]}
                               + 15'h0001;
            fb_wide_ratio   <= {1'b0, fbw_value} + 11'h001;
            fb_narrow_ratio <= {1'b0, cfg2_reg[FBN_LSB +: 8]}
                               + 9'h001;
        end
    end

    // Reset, sync and calibration controls; register contents survive
    // the soft reset because only core_hold follows bit 6
    assign psa_code = cfg3_reg[PSA_LSB +: 2];
    assign psb_code = cfg3_reg[PSB_LSB +: 2];
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            core_hold              <= 1'b1;
            divider_sync_hold      <= 1'b1;
            vco_calibration_en     <= 1'b0;
            prescaler_first_ratio  <= RATIO4;
            prescaler_second_ratio <= RATIO4;
            prescaler_code_err     <= 1'b0;
        end
        else if (ce)
        begin
            core_hold              <= !cfg3_reg[SRST_BIT];
            divider_sync_hold      <= !cfg3_reg[SYNC_BIT];
            vco_calibration_en     <= cfg3_reg[CAL_BIT];
            prescaler_first_ratio  <= presc_ratio(psa_code);
            prescaler_second_ratio <= presc_ratio(psb_code);
            // Reserved code is stored for readback but flagged
            prescaler_code_err     <= (&psa_code) || (&psb_code);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_wr_r1;
        ce && word_stb && word_addr == OFF_REFDIV_FBHI;
    endsequence

    a_tie_bit_high: assert property (cfg0_reg[TIE_BIT])
        else $error("register 0 bit 0 not held at one");
    a_resv_zero: assert property (cfg0_reg[15:10] == 6'h00
                                  && cfg3_reg[15:13] == 3'h0)
        else $error("reserved bits do not read zero");
    a_write_lands: assert property (s_wr_r1 |=>
                                    cfg1_reg == $past(word_data))
        else $error("register 1 write not stored");
    a_refdiv_ratio: assert property (ce |=> ref_div_ratio ==
        {1'b0, $past(cfg1_reg[15:2])} + 15'h0001)
        else $error("reference ratio not value plus one");
    a_status_a_off: assert property (ce && en_a == 3'h0 |=> !status_a)
        else $error("status A driven while all sources disabled");
    a_status_b_on: assert property (ce && |(src_reg & en_b) |=> status_b)
        else $error("status B missing an enabled source");
    a_soft_hold: assert property (ce |=> core_hold ==
                                  !$past(cfg3_reg[SRST_BIT]))
        else $error("core hold does not follow bit 6");
    a_sync_hold: assert property (ce && !cfg3_reg[SYNC_BIT]
                                  |=> divider_sync_hold)
        else $error("dividers not held in sync");
    a_pump_value: assert property (ce |=> pump_current_ua == 12'(
        PUMP_STEP_UA * ({9'h000, $past(cfg0_reg[3:1])} + 12'h001)))
        else $error("pump current mismatch");
    a_read_answer: assert property (ce && host_rd_stb |=> host_rd_valid
        ##1 (!$past(ce) || !$past(host_rd_stb) || host_rd_valid))
        else $error("read answer not given next cycle");
endmodule
`default_nettype wire

// File: test/pcr_bank_tb.sv
// Self-checking testbench for the PLL configuration register bank
`timescale 1ns/1ps
`default_nettype none
module pcr_bank_tb;
    import pcr_pkg::*;
    logic        core_clk, rst_b, ce, host_wr_stb, host_rd_stb, host_msb;
    logic [4:0]  host_addr;
    logic [7:0]  host_wr_byte, host_rd_byte;
    logic        host_rd_valid, ref_clk_ok, ref_lost, pll_locked;
    logic        status_a, status_b, core_hold, divider_sync_hold;
    logic        vco_calibration_en, prescaler_code_err;
    logic [2:0]  filter_cap_sel, filter_res_sel, pump_current_sel;
    logic [2:0]  prescaler_first_ratio, prescaler_second_ratio;
    logic [12:0] filter_cap_tenth_pf;
    logic [11:0] filter_res_ohm, pump_current_ua;
    logic [14:0] ref_div_ratio;
    logic [10:0] fb_wide_ratio;
    logic [8:0]  fb_narrow_ratio;
    logic [15:0] shadow [4];
    logic [15:0] rd, d;
    logic [4:0]  a;
    logic [5:0]  en;
    logic [2:0]  s;
    int          bad_count = 0;
    int          n_tests = 0;
    int          cycles = 0;
    // Capacitor in tenths of pF (code 6 undefined) and resistor in ohms
    localparam logic [15:0] CAP_TBL [8] = '{16'h015E, 16'h0465, 16'h06EF,
        16'h0979, 16'h0C1C, 16'h0EBF, 16'h0000, 16'h15F9};
    localparam logic [15:0] RES_TBL [8] = '{16'h000A, 16'h001E, 16'h003C,
        16'h0064, 16'h0212, 16'h041A, 16'h0820, 16'h0FAA};

    pcr_bank i_pcr_bank (
        .core_clk, .rst_b, .ce, .host_wr_stb, .host_rd_stb, .host_msb,
        .host_addr, .host_wr_byte, .host_rd_byte, .host_rd_valid,
        .ref_clk_ok, .ref_lost, .pll_locked, .status_a, .status_b,
        .filter_cap_sel, .filter_cap_tenth_pf, .filter_res_sel,
        .filter_res_ohm, .pump_current_sel, .pump_current_ua,
        .ref_div_ratio, .fb_wide_ratio, .fb_narrow_ratio, .core_hold,
        .divider_sync_hold, .vco_calibration_en, .prescaler_first_ratio,
        .prescaler_second_ratio, .prescaler_code_err
    );

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Cut a hang short; the whole run needs far fewer cycles
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            bad_count = bad_count + 1;
            close_out();
        end
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Expected content after a write: reserved bits cleared, bit 0 tied
    function automatic logic [15:0] stored(input logic [4:0] ad,
                                           input logic [15:0] dd);
        if (ad == 5'h00)
            return (dd & R0_WMASK) | R0_TIE;
        if (ad == 5'h03)
            return dd & R3_WMASK;
        return dd;
    endfunction

    function automatic logic [2:0] ps(input logic [1:0] c);
        return (c == 2'h3) ? 3'h0 : 3'h4 + 3'(c);
    endfunction

    // High byte then low byte back to back; addresses may differ
    task automatic wr_pair(input logic [4:0] ah, input logic [4:0] al,
                           input logic [15:0] dd);
        @(posedge core_clk);
        host_wr_stb <= 1'b1;
        host_msb <= 1'b1;
        host_addr <= ah;
        host_wr_byte <= dd[15:8];
        @(posedge core_clk);
        host_msb <= 1'b0;
        host_addr <= al;
        host_wr_byte <= dd[7:0];
        @(posedge core_clk);
        host_wr_stb <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic rd_reg(input logic [4:0] ad, output logic [15:0] dd);
        for (int i = 1; i >= 0; i--)
        begin
            @(posedge core_clk);
            host_rd_stb <= 1'b1;
            host_msb <= i[0];
            host_addr <= ad;
            @(posedge core_clk);
            host_rd_stb <= 1'b0;
            // The valid pulse stands only in the cycle after the strobe
            #1;
            chk({15'h0000, host_rd_valid}, 16'h0001);
            if (i == 1)
                dd[15:8] = host_rd_byte;
            else
                dd[7:0] = host_rd_byte;
        end
    endtask

    // Derived outputs against the shadow copy of the registers
    task automatic chk_out();
        chk(16'(filter_cap_sel), 16'(shadow[0][9:7]));
        chk(16'(filter_cap_tenth_pf), CAP_TBL[shadow[0][9:7]]);
        chk(16'(filter_res_sel), 16'(shadow[0][6:4]));
        chk(16'(filter_res_ohm), RES_TBL[shadow[0][6:4]]);
        chk(16'(pump_current_sel), 16'(shadow[0][3:1]));
        chk(16'(pump_current_ua),
            16'h01F4 * (16'(shadow[0][3:1]) + 16'h0001));
        chk(16'(ref_div_ratio), 16'(shadow[1][15:2]) + 16'h0001);
        chk(16'(fb_wide_ratio),
            16'({shadow[1][1:0], shadow[2][15:8]}) + 16'h0001);
        chk(16'(fb_narrow_ratio), 16'(shadow[2][7:0]) + 16'h0001);
        chk({13'h0000, core_hold, divider_sync_hold, vco_calibration_en},
            {13'h0000, ~shadow[3][6:5], shadow[3][4]});
        chk({10'h000, prescaler_second_ratio, prescaler_first_ratio},
            {10'h000, ps(shadow[3][3:2]), ps(shadow[3][1:0])});
        chk(16'(prescaler_code_err),
            16'(&shadow[3][3:2] | &shadow[3][1:0]));
    endtask

    task automatic wr_chk(input logic [4:0] ad, input logic [15:0] dd);
        wr_pair(ad, ad, dd);
        shadow[ad[1:0]] = stored(ad, dd);
        rd_reg(ad, rd);
        chk(rd, shadow[ad[1:0]]);
        chk_out();
    endtask

    initial
    begin
        rst_b = 1'b0;
        ce = 1'b1;
        host_wr_stb = 1'b0;
        host_rd_stb = 1'b0;
        host_msb = 1'b0;
        host_addr = 5'h00;
        host_wr_byte = 8'h00;
        {ref_clk_ok, ref_lost, pll_locked} = 3'h0;
        shadow = '{R0_RST, R1_RST, R2_RST, R3_RST};
        void'($urandom(38));
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            rd_reg(5'(i), rd);
            chk(rd, shadow[i]);
        end
        chk_out();
        $display("test reset values done");
        // Every code of the three filter and pump fields, bit 0 written 0
        for (int c = 0; c < 8; c++)
            wr_chk(5'h00, {6'h3F, 3'(c), 3'(7 - c), 3'(c), 1'b0});
        $display("test field codes done");
        // Every prescaler code, reserved one included, with control bits
        for (int c = 0; c < 16; c++)
            wr_chk(5'h03, 16'($urandom) & 16'hFF80 | 16'(c * 17 & 'h7F));
        $display("test prescaler codes done");
        for (int k = 0; k < 40; k++)
        begin
            a = 5'($urandom % 4);
            // Ordinary host traffic keeps the reserved bits at zero
            d = 16'($urandom);
            if (a == OFF_FILTER_PUMP)
                d[15:10] = 6'h00;
            if (a == OFF_STATUS_CTRL)
                d[15:13] = 3'h0;
            wr_chk(a, d);
        end
        $display("test random writes done");
        // Refused traffic: unmapped place, split pair, orphan low byte
        wr_pair(5'h07, 5'h07, 16'hA5A5);
        rd_reg(5'h07, rd);
        chk(rd, 16'h0000);
        wr_pair(5'h01, 5'h02, 16'($urandom));
        @(posedge core_clk);
        host_wr_stb <= 1'b1;
        host_msb <= 1'b0;
        host_addr <= 5'h02;
        host_wr_byte <= 8'h5A;
        @(posedge core_clk);
        host_wr_stb <= 1'b0;
        repeat (4) @(posedge core_clk);
        for (int i = 1; i < 3; i++)
        begin
            rd_reg(5'(i), rd);
            chk(rd, shadow[i]);
        end
        $display("test refused writes done");
        // Status pins: OR of enabled sources after the synchronisers
        for (int k = 0; k < 24; k++)
        begin
            en = 6'($urandom);
            s = 3'($urandom);
            d = shadow[3] & 16'hE07F | {3'h0, en, 7'h00};
            wr_chk(5'h03, d);
            @(posedge core_clk);
            {ref_clk_ok, ref_lost, pll_locked} <= s;
            repeat (8) @(posedge core_clk);
            #1;
            chk({14'h0000, status_b, status_a},
                {14'h0000, |(en[5:3] & s), |(en[2:0] & s)});
        end
        $display("test status pins done");
        // Clock enable low freezes every flop, synchronisers included
        @(posedge core_clk);
        ce <= 1'b0;
        {ref_clk_ok, ref_lost, pll_locked} <= ~s;
        repeat (8) @(posedge core_clk);
        #1;
        chk({14'h0000, status_b, status_a},
            {14'h0000, |(en[5:3] & s), |(en[2:0] & s)});
        @(posedge core_clk);
        ce <= 1'b1;
        repeat (8) @(posedge core_clk);
        #1;
        chk({14'h0000, status_b, status_a},
            {14'h0000, |(en[5:3] & ~s), |(en[2:0] & ~s)});
        $display("test clock enable done");
        close_out();
    end
endmodule
`default_nettype wire
